// file: rtl/dds_dma.sv
// Seven-channel cascaded DMA subsystem with page registers, refresh timing and a write FIFO.
`timescale 1ns/1ns
`default_nettype none

module dds_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [CW-1:0]    cnt;
	logic             push;
	logic             pop;
	// The output stage is a register so the memory side sees clean flop outputs.
	assign in_ready_o = cnt != CW'(DEPTH);
	assign push = in_valid_i && in_ready_o;
	assign pop = (cnt != '0) && (!out_valid_o || out_ready_i);
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr      <= '0;
			rd_ptr      <= '0;
			cnt         <= '0;
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
			begin
				rd_ptr     <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
				out_data_o <= mem[rd_ptr];
			end
			if (pop)
				out_valid_o <= 1'b1;
			else if (out_ready_i)
				out_valid_o <= 1'b0;
			cnt <= cnt + CW'(push) - CW'(pop);
		end
	end
endmodule

// How it works
// RQ1: Low controller cascades into channel four; seven channels.
// RQ2: Byte channels: counter low sixteen, page high eight.
// RQ3: Byte block ends after 64K transfers.
// RQ4: Word channels: counter A1-A16, page A17-A23.
// RQ5: Word blocks at most 128K, A0 always zero.
// RQ6: Counter wrap never carries into the page.
// RQ7: Each channel moves only its fixed width.
// RQ8: DMA timing runs at half the core rate.
// RQ9: Software keeps single transfer mode for refresh.
// RQ10: Acquire 2.5, transfer 5, release 1.5 clocks.
// RQ11: Channels 0-3 byte wide, 5-7 word wide.
// RQ12: Refresh every 15 us with internal row.
// RQ13: Page registers decoded at 0080h to 009Fh.
// RQ14: Word controller decoded at 00C0h to 00DFh.
// RQ15: Requests held till acknowledge; fixed priority, one transfer.
module dds_dma import dds_pkg::*; #(
	parameter int REFRESH_CYCLES = REFRESH_CYC,
	parameter int BUF_DEPTH      = FIFO_DEPTH
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  dreq_i,
	output logic      [7:0]  dack_o,
	output logic             hold_req_o,
	input  wire logic        hold_ack_i,
	input  wire logic [15:0] dev_data_i,
	output logic             tc_o,
	output logic             refresh_o,
	output logic      [7:0]  refresh_row_o,
	input  wire logic [15:0] io_addr_i,
	input  wire logic        io_wr_i,
	input  wire logic        io_rd_i,
	input  wire logic [7:0]  io_wdata_i,
	output logic      [7:0]  io_rdata_o,
	output logic             mem_valid_o,
	input  wire logic        mem_ready_i,
	output logic      [23:0] mem_addr_o,
	output logic      [15:0] mem_data_o,
	output logic             mem_word_o
);
	localparam int RT_W = $clog2(REFRESH_CYCLES);

	function automatic logic [1:0] pick4(input logic [3:0] req);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--)
			if (req[i])
				r = 2'(i);
		return r;
	endfunction

	dds_state_t       state;
	logic [3:0]       tmr;
	logic [2:0]       grant_ch;
	logic             dma_ce;
	logic [7:0]       dreq_meta;
	logic [7:0]       dreq_s;
	logic             hack_meta;
	logic             hack_s;
	logic [15:0]      dev_meta;
	logic [15:0]      dev_s;
	logic [7:0]       page [8];
	logic [15:0]      cur_addr [8];
	logic [15:0]      cur_cnt [8];
	logic [7:0]       mask;
	logic [7:0]       tc_flag;
	logic [1:0]       ptr;
	logic [RT_W-1:0]  rfsh_cnt;
	logic             rfsh_pend;
	logic             rfsh_tick;
	logic [7:0]       active;
	logic             low_req;
	logic [2:0]       win;
	logic             start_ok;
	logic             fifo_ready;
	logic             push;
	logic             push_word;
	logic [23:0]      push_addr;
	logic [15:0]      push_data;
	logic             page_hit;
	logic             ctl1_hit;
	logic             ctl2_hit;
	logic             ctl_hit;
	logic [4:0]       off;
	logic [2:0]       io_ch;
	logic             ctl_sel;
	logic             chan_reg;
	logic [15:0]      chan_word;
	logic [7:0]       next_rdata;
	logic             last_xfer;

	assign rfsh_tick = rfsh_cnt == RT_W'(REFRESH_CYCLES - 1);
	assign active = dreq_s & ~mask & CHAN_USABLE;
	assign low_req = |active[3:0];
	// The low controller's request enters the word controller as its top-priority channel four.
	assign win = low_req ? {1'b0, pick4(active[3:0])} : {1'b1, pick4({active[7:5], 1'b0})}; // see RQ1 see RQ15
	// A grant still held from the last cycle must drop first, or a stale acknowledge would be taken as new.
	assign start_ok = (|active) && fifo_ready && !hack_s;
	assign push = (state == ST_XFER) && (tmr == '0);
	assign push_word = grant_ch[2]; // see RQ7 see RQ11
	// Only the low sixteen bits count, so a wrap stays inside the page.
	assign push_addr = push_word ? {page[grant_ch][7:1], cur_addr[grant_ch], 1'b0}
		: {page[grant_ch], cur_addr[grant_ch]}; // see RQ2 see RQ4 see RQ5 see RQ6
	assign push_data = push_word ? dev_s : {8'h00, dev_s[7:0]}; // see RQ7
	assign last_xfer = cur_cnt[grant_ch] == CNT_LAST; // see RQ3 see RQ5
	assign page_hit = (io_addr_i >= PAGE_LO) && (io_addr_i <= PAGE_HI); // see RQ13
	assign ctl1_hit = (io_addr_i >= CTL1_LO) && (io_addr_i <= CTL1_HI);
	assign ctl2_hit = (io_addr_i >= CTL2_LO) && (io_addr_i <= CTL2_HI); // see RQ14
	assign ctl_hit = ctl1_hit || ctl2_hit;
	// The word controller sits on even addresses only, so its offset drops bit zero.
	assign off = ctl2_hit ? io_addr_i[5:1] : io_addr_i[4:0]; // see RQ14
	assign ctl_sel = ctl2_hit;
	assign io_ch = {ctl_sel, off[2:1]};
	assign chan_reg = ctl_hit && (off < REG_CHAN_END);
	assign chan_word = off[0] ? cur_cnt[io_ch] : cur_addr[io_ch];
	assign next_rdata = page_hit ? page[io_addr_i[2:0]]
		: chan_reg ? (ptr[ctl_sel] ? chan_word[15:8] : chan_word[7:0])
		: (ctl_hit && off == REG_STATUS) ? (ctl_sel ? {dreq_s[7:4], tc_flag[7:4]} : {dreq_s[3:0], tc_flag[3:0]})
		: 8'h00;

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dreq_meta <= '0;
			dreq_s    <= '0;
			hack_meta <= 1'b0;
			hack_s    <= 1'b0;
			dev_meta  <= '0;
			dev_s     <= '0;
			dma_ce    <= 1'b0;
		end
		else
		begin
			dreq_meta <= dreq_i;
			dreq_s    <= dreq_meta;
			hack_meta <= hold_ack_i;
			hack_s    <= hack_meta;
			dev_meta  <= dev_data_i;
			dev_s     <= dev_meta;
			dma_ce    <= ~dma_ce; // see RQ8
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rfsh_cnt  <= '0;
			rfsh_pend <= 1'b0;
		end
		else
		begin
			rfsh_cnt <= rfsh_tick ? '0 : rfsh_cnt + 1'b1; // see RQ12
			if (rfsh_tick)
				rfsh_pend <= 1'b1;
			else if (state == ST_IDLE && dma_ce)
				rfsh_pend <= 1'b0;
		end
	end

	// Single transfer per grant: the bus goes back after every cycle, which lets refresh in.
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state         <= ST_IDLE;
			tmr           <= '0;
			grant_ch      <= '0;
			dack_o        <= '0;
			hold_req_o    <= 1'b0;
			refresh_o     <= 1'b0;
			refresh_row_o <= '0;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
					if (dma_ce && rfsh_pend)
					begin
						state     <= ST_RFSH;
						tmr       <= 4'(RFSH_CYC - 1);
						refresh_o <= 1'b1; // see RQ12
					end
					else if (dma_ce && start_ok)
					begin
						state      <= ST_ACQ;
						tmr        <= 4'(ACQ_CYC - 1);
						grant_ch   <= win; // see RQ15
						hold_req_o <= 1'b1;
					end
				ST_ACQ:
					if (hack_s)
					begin
						if (tmr == '0)
						begin
							state  <= ST_XFER;
							tmr    <= 4'(XFER_CYC - 1);
							dack_o <= 8'h01 << grant_ch; // see RQ10
						end
						else
							tmr <= tmr - 1'b1;
					end
				ST_XFER:
					if (tmr == '0)
					begin
						state  <= ST_REL;
						tmr    <= 4'(REL_CYC - 1);
						dack_o <= '0; // see RQ10
					end
					else
						tmr <= tmr - 1'b1;
				ST_REL:
					if (tmr == '0)
					begin
						state      <= ST_IDLE;
						hold_req_o <= 1'b0; // see RQ10
					end
					else
						tmr <= tmr - 1'b1;
				ST_RFSH:
					if (tmr == '0)
					begin
						state         <= ST_IDLE;
						refresh_o     <= 1'b0;
						refresh_row_o <= refresh_row_o + 1'b1; // see RQ12
					end
					else
						tmr <= tmr - 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 8; i++)
			begin
				page[i]     <= '0;
				cur_addr[i] <= '0;
				cur_cnt[i]  <= '0;
			end
			mask       <= MASK_RST;
			tc_flag    <= '0;
			ptr        <= '0;
			tc_o       <= 1'b0;
			io_rdata_o <= '0;
		end
		else
		begin
			tc_o <= push && last_xfer;
			if (io_rd_i)
				io_rdata_o <= next_rdata;
			// Reading status clears its flags, but a count ending in the same cycle still sets.
			if (io_rd_i && ctl_hit && off == REG_STATUS)
			begin
				if (ctl_sel)
					tc_flag[7:4] <= '0;
				else
					tc_flag[3:0] <= '0;
			end
			if (io_wr_i && page_hit)
				page[io_addr_i[2:0]] <= io_wdata_i; // see RQ13
			if (io_wr_i && ctl_hit && off == REG_MASK)
				mask[{ctl_sel, io_wdata_i[1:0]}] <= io_wdata_i[MASK_SET_BIT];
			if (io_wr_i && ctl_hit && off == REG_CLRPTR)
				ptr[ctl_sel] <= 1'b0;
			if ((io_wr_i || io_rd_i) && chan_reg)
				ptr[ctl_sel] <= ~ptr[ctl_sel];
			if (push)
			begin
				cur_addr[grant_ch] <= cur_addr[grant_ch] + 1'b1; // see RQ6
				cur_cnt[grant_ch]  <= cur_cnt[grant_ch] - 1'b1;
				if (last_xfer)
				begin
					tc_flag[grant_ch] <= 1'b1; // see RQ3
					mask[grant_ch]    <= 1'b1;
				end
			end
			if (io_wr_i && chan_reg)
			begin
				if (off[0])
				begin
					if (ptr[ctl_sel])
						cur_cnt[io_ch][15:8] <= io_wdata_i;
					else
						cur_cnt[io_ch][7:0] <= io_wdata_i;
				end
				else
				begin
					if (ptr[ctl_sel])
						cur_addr[io_ch][15:8] <= io_wdata_i;
					else
						cur_addr[io_ch][7:0] <= io_wdata_i;
				end
			end
		end
	end

	dds_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (BUF_DEPTH)
	) u_fifo (
		.clk_i       (core_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (push),
		.in_ready_o  (fifo_ready),
		.in_data_i   ({push_addr, push_data, push_word}),
		.out_valid_o (mem_valid_o),
		.out_ready_i (mem_ready_i),
		.out_data_o  ({mem_addr_o, mem_data_o, mem_word_o})
	);

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_dack_on;
		(|dack_o) [*8] ##1 (|dack_o) [*2];
	endsequence
	sequence s_release;
		hold_req_o [*3] ##1 !hold_req_o;
	endsequence

	localparam int CASCADE_IDX   = 4;
	localparam int RFSH_WAIT_MAX = 40;

	property p_no_cascade_ack;
		$onehot0(dack_o) && !dack_o[CASCADE_IDX];
	endproperty
	a_no_cascade_ack: assert property (p_no_cascade_ack) else $error("cascade channel acknowledged"); // see RQ1
	property p_byte_page;
		push && !push_word |-> push_addr[23:16] == page[grant_ch] && push_addr[15:0] == cur_addr[grant_ch];
	endproperty
	a_byte_page: assert property (p_byte_page) else $error("byte address wrong"); // see RQ2
	property p_word_addr;
		push && push_word |-> !push_addr[0] && push_addr[16:1] == cur_addr[grant_ch];
	endproperty
	a_word_addr: assert property (p_word_addr) else $error("word address wrong"); // see RQ4 see RQ5
	property p_tc_stop;
		push && last_xfer |=> tc_o && mask[grant_ch] && tc_flag[grant_ch];
	endproperty
	a_tc_stop: assert property (p_tc_stop) else $error("terminal count missed"); // see RQ3
	property p_wrap_page;
		push && cur_addr[grant_ch] == 16'hFFFF && !(io_wr_i && page_hit) |=>
			cur_addr[grant_ch] == 16'h0000 && page[grant_ch] == $past(page[grant_ch]);
	endproperty
	a_wrap_page: assert property (p_wrap_page) else $error("counter carried"); // see RQ6
	property p_width;
		push |-> push_word == grant_ch[2] && (push_word || push_data[15:8] == 8'h00);
	endproperty
	a_width: assert property (p_width) else $error("width mismatch"); // see RQ7
	property p_half_rate;
		dma_ce |=> !dma_ce ##1 dma_ce;
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("dma enable not half rate"); // see RQ8
	property p_xfer_len;
		$rose(|dack_o) |-> s_dack_on ##1 !(|dack_o) ##0 s_release;
	endproperty
	a_xfer_len: assert property (p_xfer_len) else $error("transfer timing wrong"); // see RQ10
	property p_acq_len;
		$rose(|dack_o) |-> $past(hack_s, ACQ_CYC) && $past(state, ACQ_CYC) == ST_ACQ;
	endproperty
	a_acq_len: assert property (p_acq_len) else $error("acquire timing wrong"); // see RQ10
	property p_refresh;
		rfsh_tick |-> ##[1:RFSH_WAIT_MAX] refresh_o;
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh not issued"); // see RQ12
	property p_page_wr;
		io_wr_i && page_hit |=> page[$past(io_addr_i[2:0])] == $past(io_wdata_i);
	endproperty
	a_page_wr: assert property (p_page_wr) else $error("page write lost"); // see RQ13
	property p_grant;
		state == ST_IDLE && dma_ce && !rfsh_pend && start_ok |=> grant_ch == $past(win) && state == ST_ACQ;
	endproperty
	a_grant: assert property (p_grant) else $error("grant not by priority"); // see RQ15
endmodule

`default_nettype wire

// file: rtl/dds_pkg.sv
// Constants, offsets and state type shared by the dual DMA controller subsystem.
package dds_pkg;
	localparam int CPU_MHZ     = 100;
	localparam int DMA_DIV     = 2;
	localparam int CORE_PER_HALF = DMA_DIV / 2;
	localparam int ACQ_HALF    = 5;
	localparam int XFER_HALF   = 10;
	localparam int REL_HALF    = 3;
	localparam int RFSH_HALF   = 8;
	localparam int ACQ_CYC     = ACQ_HALF * CORE_PER_HALF;
	localparam int XFER_CYC    = XFER_HALF * CORE_PER_HALF;
	localparam int REL_CYC     = REL_HALF * CORE_PER_HALF;
	localparam int RFSH_CYC    = RFSH_HALF * CORE_PER_HALF;
	localparam int REFRESH_NS  = 15000;
	localparam int REFRESH_CYC = REFRESH_NS * CPU_MHZ / 1000;
	localparam logic [15:0] PAGE_LO    = 16'h0080;
	localparam logic [15:0] PAGE_HI    = 16'h009F;
	localparam logic [15:0] CTL1_LO    = 16'h0000;
	localparam logic [15:0] CTL1_HI    = 16'h001F;
	localparam logic [15:0] CTL2_LO    = 16'h00C0;
	localparam logic [15:0] CTL2_HI    = 16'h00DF;
	localparam logic [4:0]  REG_CHAN_END = 5'h08;
	localparam logic [4:0]  REG_STATUS = 5'h08;
	localparam logic [4:0]  REG_MASK   = 5'h0A;
	localparam logic [4:0]  REG_CLRPTR = 5'h0C;
	localparam int          MASK_SET_BIT = 2;
	localparam logic [7:0]  MASK_RST   = 8'hFF;
	localparam logic [7:0]  CHAN_USABLE = 8'hEF;
	localparam logic [15:0] CNT_LAST   = 16'h0000;
	localparam int          ADDR_W     = 24;
	localparam int          DATA_W     = 16;
	localparam int          FIFO_W     = ADDR_W + DATA_W + 1;
	localparam int          FIFO_DEPTH = 16;
	typedef enum logic [2:0] {ST_IDLE, ST_ACQ, ST_XFER, ST_REL, ST_RFSH} dds_state_t;
endpackage

// file: tb/dds_adapter_model.sv
// Behavioural model of the requesting adapters and of the bus owner that grants hold.
`timescale 1ns/1ns
`default_nettype none
module dds_adapter_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  load_i,
	input  wire logic [7:0]  load_cnt_i,
	input  wire logic [3:0]  ack_dly_i,
	input  wire logic [7:0]  dack_i,
	input  wire logic        hold_req_i,
	output logic      [7:0]  dreq_o,
	output logic             hold_ack_o,
	output logic      [15:0] data_o
);
	logic [7:0] rem [8];
	logic [7:0] done [8];
	logic [7:0] seen;
	logic [3:0] wait_cnt;

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dreq_o <= 8'h00;
			seen   <= 8'h00;
			data_o <= 16'h0000;
			for (int c = 0; c < 8; c++)
			begin
				rem[c]  <= 8'h00;
				done[c] <= 8'h00;
			end
		end
		else
		begin
			// Released data lines must not keep the last value, or a late sample would pass.
			if (dack_i == 8'h00)
				data_o <= ~data_o;
			for (int c = 0; c < 8; c++)
			begin
				if (load_i[c])
					rem[c] <= load_cnt_i;
				else if (dack_i[c] && !seen[c])
				begin
					seen[c]   <= 1'b1;
					dreq_o[c] <= 1'b0;
					rem[c]    <= rem[c] - 8'h01;
					done[c]   <= done[c] + 8'h01;
					data_o    <= {c[3:0], 4'h5, done[c]};
				end
				else if (!dack_i[c])
				begin
					seen[c]   <= 1'b0;
					dreq_o[c] <= (rem[c] != 8'h00);
				end
			end
		end
	end

	// The grant may come promptly or late, as a busy processor would give it.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i || !hold_req_i)
		begin
			wait_cnt   <= 4'h0;
			hold_ack_o <= 1'b0;
		end
		else if (wait_cnt >= ack_dly_i)
			hold_ack_o <= 1'b1;
		else
			wait_cnt <= wait_cnt + 4'h1;
	end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the dual DMA controller subsystem.
`timescale 1ns/1ns
`default_nettype none
module tb_top import dds_pkg::*;;
	logic        clk;
	logic        rst;
	logic [7:0]  dreq;
	logic [7:0]  dack;
	logic        hold_req;
	logic        hold_ack;
	logic [15:0] dev_data;
	logic        tc;
	logic        rfsh;
	logic [7:0]  row;
	logic [15:0] io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic        mem_valid;
	logic        mem_ready;
	logic [23:0] mem_addr;
	logic [15:0] mem_data;
	logic        mem_word;
	logic [7:0]  load;
	logic [7:0]  load_cnt;
	logic [3:0]  ack_dly;
	logic [40:0] q[$];
	logic [7:0]  rd;
	logic        saw4 = 1'b0;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          run = 0;
	int          last_w = 0;
	int          n_dack = 0;
	int          n_tc = 0;

	dds_dma #(.REFRESH_CYCLES(400)) u_dut (.core_clk_i(clk), .rst_i(rst), .dreq_i(dreq), .dack_o(dack),
		.hold_req_o(hold_req), .hold_ack_i(hold_ack), .dev_data_i(dev_data), .tc_o(tc), .refresh_o(rfsh),
		.refresh_row_o(row), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
		.io_rdata_o(io_rdata), .mem_valid_o(mem_valid), .mem_ready_i(mem_ready), .mem_addr_o(mem_addr),
		.mem_data_o(mem_data), .mem_word_o(mem_word));
	dds_adapter_model u_adapter (.clk_i(clk), .rst_i(rst), .load_i(load), .load_cnt_i(load_cnt),
		.ack_dly_i(ack_dly), .dack_i(dack), .hold_req_i(hold_req), .dreq_o(dreq), .hold_ack_o(hold_ack),
		.data_o(dev_data));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (mem_valid && mem_ready)
			q.push_back({mem_word, mem_addr, mem_data});
		if (dack != 8'h00)
			run++;
		else if (run != 0)
		begin
			last_w = run;
			run = 0;
			n_dack++;
		end
		if (dack[4])
			saw4 = 1'b1;
		if (tc)
			n_tc++;
	end

	task automatic end_of_test;
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		tick(1);
		io_wr = 1'b0;
		tick(1);
	endtask

	task automatic rdr(input logic [15:0] a);
		io_addr = a;
		io_rd = 1'b1;
		tick(1);
		io_rd = 1'b0;
		tick(1);
		rd = io_rdata;
	endtask

	// Word controller registers sit on even addresses, so offsets are doubled there.
	function automatic logic [15:0] reg_at(input int ch, input int off);
		return (ch < 4) ? 16'(off) : 16'h00C0 + 16'(off * 2);
	endfunction

	task automatic prog(input int ch, input logic [15:0] a, input logic [15:0] n, input logic [7:0] pg);
		wr(reg_at(ch, 12), 8'h00);
		wr(reg_at(ch, 2 * (ch % 4)), a[7:0]);
		wr(reg_at(ch, 2 * (ch % 4)), a[15:8]);
		wr(reg_at(ch, 2 * (ch % 4) + 1), n[7:0]);
		wr(reg_at(ch, 2 * (ch % 4) + 1), n[15:8]);
		wr(16'h0080 + 16'(ch), pg);
		wr(reg_at(ch, 10), 8'(ch % 4));
	endtask

	task automatic req(input logic [7:0] m, input logic [7:0] n);
		load = m;
		load_cnt = n;
		tick(1);
		load = 8'h00;
	endtask

	task automatic wait_items(input int n);
		int i;
		for (i = 0; i < 3000 && q.size() < n; i++)
			tick(1);
		if (q.size() < n)
		begin
			n_mismatch++;
			end_of_test();
		end
	endtask

	task automatic t_io;
		wr(16'h0086, 8'h5A);
		rdr(16'h0086);
		chk("page reg", rd, 8'h5A);
		rdr(16'h008E);
		chk("page alias", rd, 8'h5A);
		rdr(16'h0050);
		chk("unmapped", rd, 8'h00);
		wr(16'h00D8, 8'h00);
		wr(16'h00C4, 8'hA5);
		wr(16'h00C4, 8'h3C);
		wr(16'h00D8, 8'h00);
		rdr(16'h00C4);
		chk("ctl2 lo", rd, 8'hA5);
		rdr(16'h00C4);
		chk("ctl2 hi", rd, 8'h3C);
	endtask

	task automatic t_byte;
		int tc0;
		tc0 = n_tc;
		q.delete();
		prog(2, 16'hFFFF, 16'h0001, 8'h12);
		req(8'h14, 8'h02);
		wait_items(2);
		chk("addr0", q[0][39:16], 24'h12FFFF);
		chk("addr1", q[1][39:16], 24'h120000);
		chk("width", q[1][40], 1'b0);
		chk("data", q[1][7:0], 8'h01);
		chk("dack len", last_w, XFER_CYC);
		chk("tc", n_tc - tc0, 1);
		chk("cascade", saw4, 1'b0);
		rdr(16'h0008);
		chk("status", rd, 8'h04);
		rdr(16'h0008);
		chk("status clr", rd, 8'h00);
	endtask

	task automatic t_word;
		q.delete();
		ack_dly = 4'h9;
		prog(7, 16'h1234, 16'h0000, 8'h35);
		req(8'h80, 8'h01);
		wait_items(1);
		chk("waddr", q[0][39:16], 24'h342468);
		chk("wflag", q[0][40], 1'b1);
		chk("wdata", q[0][15:0], 16'h7500);
		ack_dly = 4'h0;
	endtask

	task automatic t_prio;
		q.delete();
		prog(3, 16'h0000, 16'h0000, 8'h03);
		prog(0, 16'h0000, 16'h0000, 8'h01);
		req(8'h09, 8'h01);
		wait_items(2);
		chk("first", q[0][39:32], 8'h01);
		chk("second", q[1][39:32], 8'h03);
	endtask

	task automatic t_fifo;
		int d0;
		q.delete();
		mem_ready = 1'b0;
		d0 = n_dack;
		prog(1, 16'h0100, 16'h0013, 8'h20);
		req(8'h02, 8'h14);
		tick(1200);
		chk("stall", (n_dack - d0) < 20, 1'b1);
		mem_ready = 1'b1;
		wait_items(20);
		for (int k = 0; k < 20; k++)
		begin
			chk("faddr", q[k][39:16], {8'h20, 16'h0100 + 16'(k)});
			chk("fdata", q[k][7:0], 8'(k));
		end
	endtask

	task automatic t_refresh;
		int w;
		logic [7:0] r1;
		for (int p = 0; p < 2; p++)
		begin
			w = 0;
			// A refresh already under way would be measured short, so let it finish first.
			for (int i = 0; i < 100 && rfsh; i++)
				tick(1);
			for (int i = 0; i < 1000 && !rfsh; i++)
				tick(1);
			for (int i = 0; i < 100 && rfsh; i++)
			begin
				tick(1);
				w++;
			end
			chk("rfsh len", w, RFSH_CYC);
			tick(1);
			if (p == 0)
				r1 = row;
		end
		chk("row", row, r1 + 8'h01);
	endtask

	initial
	begin
		rst = 1'b1;
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
		mem_ready = 1'b1;
		load = 8'h00;
		load_cnt = 8'h00;
		ack_dly = 4'h0;
		tick(12);
		rst = 1'b0;
		chk("idle dack", dack, 8'h00);
		chk("idle hold", hold_req, 1'b0);
		t_io();
		t_byte();
		t_word();
		t_prio();
		t_fifo();
		t_refresh();
		end_of_test();
	end
endmodule
`default_nettype wire
